// [hw/wear_pkg.sv]
// constants, register map and types of the breaker wear monitor
// assumes a 10 MHz system clock and classic wishbone register access
package wear_pkg;

  localparam int CLK_HZ               = 10_000_000;
  localparam int CAPTURE_LIMIT_MS     = 1000;
  localparam int CAPTURE_LIMIT_CYCLES = CLK_HZ / 1000 * CAPTURE_LIMIT_MS;

  localparam int TIMER_W = 24;
  localparam int CUR_W   = 16;
  localparam int CNT_W   = 17;
  localparam int ACC_W   = 32;
  localparam int FRAC_W  = 8;
  localparam int ADR_W   = 8;

  // byte offsets
  localparam logic [ADR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_MIN_CUR  = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_CNT_1KA  = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_CNT_RATE = 8'h0C;
  localparam logic [ADR_W-1:0] ADDR_LIMIT    = 8'h10;
  localparam logic [ADR_W-1:0] ADDR_RATE_CUR = 8'h14;
  localparam logic [ADR_W-1:0] ADDR_WEAR     = 8'h18;
  localparam logic [ADR_W-1:0] ADDR_STATUS   = 8'h1C;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_ALARM_BIT  = 0;
  localparam int STAT_CAPT_BIT   = 1;
  localparam int STAT_ABORT_BIT  = 2;
  localparam int STAT_PEAK_LSB   = 16;

  // settings ranges, currents in 0.01 kA units
  localparam logic [31:0] MIN_CUR_LO  = 32'h0000_000A;
  localparam logic [31:0] MIN_CUR_HI  = 32'h0000_0032;
  localparam logic [31:0] MIN_CUR_DEF = 32'h0000_000A;
  localparam logic [31:0] RATE_CUR_LO  = 32'h0000_03E8;
  localparam logic [31:0] RATE_CUR_HI  = 32'h0000_2710;
  localparam logic [31:0] RATE_CUR_DEF = 32'h0000_03E8;
  localparam logic [31:0] COUNT_LO      = 32'h0000_0001;
  localparam logic [31:0] COUNT_HI      = 32'h0001_86A0;
  localparam logic [31:0] CNT_1KA_DEF   = 32'h0000_C350;
  localparam logic [31:0] CNT_RATE_DEF  = 32'h0000_0064;
  localparam logic [31:0] LIMIT_DEF     = 32'h0000_C350;

  // log2(100) in q8, converts 0.01 kA units to kA in the log domain
  localparam logic signed [15:0] LOG2_HUNDRED_Q8 = 16'sh06A5;
  localparam logic signed [7:0]  EXP_SAT_MAX     = 8'sh16;
  localparam logic signed [7:0]  EXP_ZERO_MIN    = -8'sh09;

  typedef enum logic [2:0] {
    IDLE    = 3'b000,
    CAPTURE = 3'b001,
    CALC_K  = 3'b010,
    CALC_E  = 3'b011,
    ACCUM   = 3'b100
  } mode_type;

  typedef struct packed {
    logic [CUR_W-1:0] phase_a;
    logic [CUR_W-1:0] phase_b;
    logic [CUR_W-1:0] phase_c;
  } phase_currents_type;

  typedef struct packed {
    logic trip_command_in;
    logic breaker_closed_in;
    logic breaker_open_in;
    logic monitor_block_in;
    logic wear_clear_in;
  } breaker_in_type;

  typedef struct packed {
    mode_type            mode;
    logic                trip_prev;
    logic [TIMER_W-1:0]  timer;
    logic [CUR_W-1:0]    peak;
    logic signed [15:0]  k_q8;
    logic signed [15:0]  lcur_q8;
    logic signed [15:0]  exp_q8;
    logic [ACC_W-1:0]    acc;
    logic                hit;
    logic                alarm;
    logic                aborted;
    logic                enable;
    logic [CUR_W-1:0]    min_cur;
    logic [CUR_W-1:0]    rated_cur;
    logic [CNT_W-1:0]    cnt_1ka;
    logic [CNT_W-1:0]    cnt_rated;
    logic [CNT_W-1:0]    limit;
    logic                ack;
    logic [31:0]         rdata;
  } core_state_type;

endpackage

// [hw/breaker_wear_monitor.sv]
// breaker contact wear monitor with classic wishbone settings registers
// assumes all breaker inputs and phase magnitudes come from logic on clk_i
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps

// Summary of operation
// - enable setting, default off, off means idle
// - block input cancels capture and suspends accumulation
// - trip command edge starts peak capture
// - capture starts only while breaker reports closed
// - capture completes only with breaker open
// - minimum current setting ends capture below it
// - permitted count at one ka setting
// - permitted count at rated current setting
// - alarm limit setting for accumulated wear
// - rated breaking current setting, second curve point
// - alarm while accumulated wear exceeds limit
// - clear input zeroes accumulated wear
// - capture over one second aborts, no wear
// - peak of three phase magnitudes tracked
// - wear readable and reloadable for backup storage
// - wear counted as one ka equivalent interruptions
module breaker_wear_monitor #(
  parameter int unsigned CAPTURE_CYCLES = wear_pkg::CAPTURE_LIMIT_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [wear_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire wear_pkg::phase_currents_type phase_i,
  input  wire wear_pkg::breaker_in_type     breaker_i,
  output logic                              wear_alarm_out_o
);

  wear_pkg::core_state_type s_q;
  wear_pkg::core_state_type s_d;

  logic                            req;
  logic                            wr;
  logic [wear_pkg::CUR_W-1:0]      max_cur;
  logic                            trip_rise;
  logic                            add_now;
  logic [wear_pkg::ACC_W-1:0]      base;
  logic [wear_pkg::ACC_W-1:0]      wear_q8;
  logic [wear_pkg::ACC_W:0]        sum;
  logic signed [15:0]              num;
  logic signed [15:0]              den;
  logic signed [23:0]              quot;
  logic signed [31:0]              prod;
  logic signed [7:0]               sh_n;
  logic [31:0]                     mant;

  function automatic logic [wear_pkg::CUR_W-1:0] max3(input wear_pkg::phase_currents_type p);
    logic [wear_pkg::CUR_W-1:0] m;
    m = (p.phase_a > p.phase_b) ? p.phase_a : p.phase_b;
    return (p.phase_c > m) ? p.phase_c : m;
  endfunction

  // mitchell log2 in q8
  function automatic logic signed [15:0] log2_q8(input logic [31:0] x);
    logic [4:0]  p;
    logic [31:0] sh;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        p = 5'(i);
      end
    end
    sh = x << (5'h1F - p);
    return signed'({3'h0, p, sh[30:23]});
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign req       = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr        = req && wb_we_i;
  assign max_cur   = max3(phase_i);
  assign trip_rise = breaker_i.trip_command_in && !s_q.trip_prev;
  assign add_now   = (s_q.mode == wear_pkg::ACCUM) && s_q.enable
                     && !breaker_i.monitor_block_in;

  always_comb begin
    s_d       = s_q;
    base      = s_q.acc;
    num       = 16'sh0000;
    den       = 16'sh0001;
    quot      = 24'sh000000;
    prod      = 32'sh00000000;
    sh_n      = s_q.exp_q8[15:8];
    mant      = {23'h000000, 1'b1, s_q.exp_q8[7:0]};
    wear_q8   = 32'h0000_0000;
    s_d.trip_prev = breaker_i.trip_command_in;
    s_d.ack   = req;
    if (req) begin
      unique case (wb_adr_i)
        wear_pkg::ADDR_CTRL:     s_d.rdata = {31'h0, s_q.enable};
        wear_pkg::ADDR_MIN_CUR:  s_d.rdata = 32'(s_q.min_cur);
        wear_pkg::ADDR_CNT_1KA:  s_d.rdata = 32'(s_q.cnt_1ka);
        wear_pkg::ADDR_CNT_RATE: s_d.rdata = 32'(s_q.cnt_rated);
        wear_pkg::ADDR_LIMIT:    s_d.rdata = 32'(s_q.limit);
        wear_pkg::ADDR_RATE_CUR: s_d.rdata = 32'(s_q.rated_cur);
        wear_pkg::ADDR_WEAR:     s_d.rdata = s_q.acc;
        wear_pkg::ADDR_STATUS: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[wear_pkg::STAT_ALARM_BIT] = s_q.alarm;
          s_d.rdata[wear_pkg::STAT_CAPT_BIT]  = (s_q.mode == wear_pkg::CAPTURE);
          s_d.rdata[wear_pkg::STAT_ABORT_BIT] = s_q.aborted;
          s_d.rdata[wear_pkg::STAT_PEAK_LSB +: wear_pkg::CUR_W] = s_q.peak;
        end
        default:                 s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        wear_pkg::ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            s_d.enable = wb_dat_i[wear_pkg::CTRL_ENABLE_BIT];
          end
        end
        wear_pkg::ADDR_MIN_CUR: s_d.min_cur = wear_pkg::CUR_W'(clamp(
          merge(32'(s_q.min_cur), wb_dat_i, wb_sel_i),
          wear_pkg::MIN_CUR_LO, wear_pkg::MIN_CUR_HI));
        wear_pkg::ADDR_CNT_1KA: s_d.cnt_1ka = wear_pkg::CNT_W'(clamp(
          merge(32'(s_q.cnt_1ka), wb_dat_i, wb_sel_i),
          wear_pkg::COUNT_LO, wear_pkg::COUNT_HI));
        wear_pkg::ADDR_CNT_RATE: s_d.cnt_rated = wear_pkg::CNT_W'(clamp(
          merge(32'(s_q.cnt_rated), wb_dat_i, wb_sel_i),
          wear_pkg::COUNT_LO, wear_pkg::COUNT_HI));
        wear_pkg::ADDR_LIMIT: s_d.limit = wear_pkg::CNT_W'(clamp(
          merge(32'(s_q.limit), wb_dat_i, wb_sel_i),
          wear_pkg::COUNT_LO, wear_pkg::COUNT_HI));
        wear_pkg::ADDR_RATE_CUR: s_d.rated_cur = wear_pkg::CUR_W'(clamp(
          merge(32'(s_q.rated_cur), wb_dat_i, wb_sel_i),
          wear_pkg::RATE_CUR_LO, wear_pkg::RATE_CUR_HI));
        wear_pkg::ADDR_WEAR: base = merge(s_q.acc, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    unique case (s_q.mode)
      wear_pkg::IDLE: begin
        if (s_q.enable && !breaker_i.monitor_block_in && trip_rise
            && breaker_i.breaker_closed_in) begin
          s_d.mode  = wear_pkg::CAPTURE;
          s_d.timer = '0;
          s_d.peak  = max_cur;
        end
      end
      wear_pkg::CAPTURE: begin
        s_d.timer = s_q.timer + 1'b1;
        if (max_cur > s_q.peak) begin
          s_d.peak = max_cur;
        end
        if (s_q.timer == wear_pkg::TIMER_W'(CAPTURE_CYCLES)) begin
          s_d.mode    = wear_pkg::IDLE;
          s_d.aborted = 1'b1;
        end else if (breaker_i.breaker_open_in && max_cur < s_q.min_cur) begin
          s_d.mode = wear_pkg::CALC_K;
        end
      end
      wear_pkg::CALC_K: begin
        // exponent of the wear line and log of the captured current in kA
        num = log2_q8(32'(s_q.cnt_1ka)) - log2_q8(32'(s_q.cnt_rated));
        if (num < 16'sh0000) begin
          num = 16'sh0000;
        end
        den = log2_q8(32'(s_q.rated_cur)) - wear_pkg::LOG2_HUNDRED_Q8;
        quot = {num, 8'h00} / 24'(den);
        s_d.k_q8    = quot[15:0];
        s_d.lcur_q8 = log2_q8(32'(s_q.peak)) - wear_pkg::LOG2_HUNDRED_Q8;
        s_d.mode    = wear_pkg::CALC_E;
      end
      wear_pkg::CALC_E: begin
        prod = s_q.k_q8 * s_q.lcur_q8;
        s_d.exp_q8 = prod[23:8];
        s_d.mode   = wear_pkg::ACCUM;
      end
      wear_pkg::ACCUM: begin
        s_d.aborted = 1'b0;
        s_d.mode    = wear_pkg::IDLE;
      end
      default: s_d.mode = wear_pkg::IDLE;
    endcase
    if (!s_q.enable || breaker_i.monitor_block_in) begin
      s_d.mode = wear_pkg::IDLE;
    end
    // wear of one interruption in q8 of 1 kA equivalents
    if (sh_n > wear_pkg::EXP_SAT_MAX) begin
      wear_q8 = 32'hFFFF_FFFF;
    end else if (sh_n >= 8'sh00) begin
      wear_q8 = mant << sh_n;
    end else if (sh_n >= wear_pkg::EXP_ZERO_MIN) begin
      wear_q8 = mant >> (-sh_n);
    end
    if (breaker_i.wear_clear_in) begin
      base = '0;
    end
    sum = {1'b0, base} + {1'b0, wear_q8};
    if (add_now) begin
      s_d.acc = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    end else begin
      s_d.acc = base;
    end
    if (add_now || breaker_i.wear_clear_in
        || (wr && (wb_adr_i == wear_pkg::ADDR_WEAR || wb_adr_i == wear_pkg::ADDR_LIMIT))) begin
      s_d.hit = (s_d.acc[wear_pkg::ACC_W-1:wear_pkg::FRAC_W] > 24'(s_d.limit));
    end
    s_d.alarm = s_d.enable && s_d.hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.mode      <= wear_pkg::IDLE;
      s_q.min_cur   <= wear_pkg::CUR_W'(wear_pkg::MIN_CUR_DEF);
      s_q.rated_cur <= wear_pkg::CUR_W'(wear_pkg::RATE_CUR_DEF);
      s_q.cnt_1ka   <= wear_pkg::CNT_W'(wear_pkg::CNT_1KA_DEF);
      s_q.cnt_rated <= wear_pkg::CNT_W'(wear_pkg::CNT_RATE_DEF);
      s_q.limit     <= wear_pkg::CNT_W'(wear_pkg::LIMIT_DEF);
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o         = s_q.rdata;
  assign wb_ack_o         = s_q.ack;
  assign wear_alarm_out_o = s_q.alarm;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_alarm_needs_enable: assert property (wear_alarm_out_o |-> s_q.enable)
    else $error("alarm while monitor disabled");
  a_disabled_stays_idle: assert property (
    !s_q.enable |=> s_q.mode == wear_pkg::IDLE)
    else $error("monitor active while disabled");
  a_block_stops_capture: assert property (
    s_q.mode == wear_pkg::CAPTURE && breaker_i.monitor_block_in
    |=> s_q.mode == wear_pkg::IDLE)
    else $error("capture continued while blocked");
  a_block_freezes_wear: assert property (
    breaker_i.monitor_block_in && !breaker_i.wear_clear_in && !wr
    |=> s_q.acc == $past(s_q.acc))
    else $error("wear changed while blocked");
  a_trip_starts_capture: assert property (
    s_q.mode == wear_pkg::IDLE && s_q.enable && !breaker_i.monitor_block_in
    && trip_rise && breaker_i.breaker_closed_in
    |=> s_q.mode == wear_pkg::CAPTURE && s_q.timer == '0)
    else $error("trip did not start capture");
  a_open_breaker_no_start: assert property (
    s_q.mode == wear_pkg::IDLE && !breaker_i.breaker_closed_in
    |=> s_q.mode == wear_pkg::IDLE)
    else $error("capture started with breaker not closed");
  a_end_needs_open: assert property (
    s_q.mode == wear_pkg::CAPTURE && !breaker_i.breaker_open_in
    |=> s_q.mode != wear_pkg::CALC_K)
    else $error("capture ended without breaker open");
  a_capture_ends_on_open: assert property (
    s_q.mode == wear_pkg::CAPTURE && s_q.enable && !breaker_i.monitor_block_in
    && breaker_i.breaker_open_in && max_cur < s_q.min_cur
    && s_q.timer != wear_pkg::TIMER_W'(CAPTURE_CYCLES)
    |=> s_q.mode == wear_pkg::CALC_K)
    else $error("capture did not end on open breaker");
  a_settings_in_range: assert property (
    32'(s_q.min_cur) >= wear_pkg::MIN_CUR_LO && 32'(s_q.min_cur) <= wear_pkg::MIN_CUR_HI
    && 32'(s_q.rated_cur) >= wear_pkg::RATE_CUR_LO
    && 32'(s_q.rated_cur) <= wear_pkg::RATE_CUR_HI
    && 32'(s_q.limit) >= wear_pkg::COUNT_LO && 32'(s_q.limit) <= wear_pkg::COUNT_HI
    && 32'(s_q.cnt_1ka) >= wear_pkg::COUNT_LO && 32'(s_q.cnt_1ka) <= wear_pkg::COUNT_HI
    && 32'(s_q.cnt_rated) >= wear_pkg::COUNT_LO
    && 32'(s_q.cnt_rated) <= wear_pkg::COUNT_HI)
    else $error("setting out of range");
  a_timeout_aborts: assert property (
    s_q.mode == wear_pkg::CAPTURE && s_q.timer == wear_pkg::TIMER_W'(CAPTURE_CYCLES)
    |=> s_q.mode == wear_pkg::IDLE && s_q.aborted
    ##1 ($stable(s_q.acc) || breaker_i.wear_clear_in))
    else $error("overlong capture not aborted");
  a_peak_tracks_max: assert property (
    s_q.mode == wear_pkg::CAPTURE |=> s_q.peak >= $past(max_cur))
    else $error("peak missed a phase maximum");
  a_clear_zeroes_wear: assert property (
    breaker_i.wear_clear_in && s_q.mode != wear_pkg::ACCUM |=> s_q.acc == '0)
    else $error("clear did not zero wear");
  a_wear_grows_after_capture: assert property (
    s_q.acc > $past(s_q.acc) |-> $past(add_now) || $past(wr))
    else $error("wear added outside a completed capture");
  a_alarm_follows_limit: assert property (
    add_now && !breaker_i.wear_clear_in && !wr
    |=> wear_alarm_out_o
        == (s_q.enable && s_q.acc[wear_pkg::ACC_W-1:wear_pkg::FRAC_W] > 24'(s_q.limit)))
    else $error("alarm disagrees with wear and limit");

endmodule // breaker_wear_monitor

// [dv/breaker_side_model.sv]
// far side model: trip command, breaker contacts and phase current source
// assumes the bench pulses go_i for one clk_i cycle per interruption
`timescale 1ns/100ps
module breaker_side_model (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    go_i,
  input  wire logic [1:0]              phase_sel_i,
  input  wire logic [15:0]             peak_i,
  input  wire logic [15:0]             tail_i,
  input  wire logic                    closed_ok_i,
  input  wire logic                    block_i,
  input  wire logic                    clear_i,
  output wear_pkg::phase_currents_type phase_o,
  output wear_pkg::breaker_in_type     breaker_o
);
  logic [4:0]  step_q;
  logic        tripping;
  logic        opening;
  logic [15:0] level;
  logic [15:0] other;

  // trip over steps 1..8, contacts part over steps 9..12, then reclose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_q <= 5'h00;
    end else if (step_q == 5'h0C) begin
      step_q <= 5'h00;
    end else if (step_q != 5'h00 || go_i) begin
      step_q <= step_q + 5'h01;
    end
  end

  always_comb begin
    tripping = (step_q != 5'h00) && (step_q < 5'h09);
    opening  = (step_q > 5'h08);
    level    = opening ? tail_i : 16'h0000;
    if (tripping) begin
      level = (step_q == 5'h05) ? peak_i : (peak_i >> 1);
    end
    other = level >> 1;
    phase_o.phase_a = (phase_sel_i == 2'h0) ? level : other;
    phase_o.phase_b = (phase_sel_i == 2'h1) ? level : other;
    phase_o.phase_c = (phase_sel_i == 2'h2) ? level : other;
    breaker_o.trip_command_in   = tripping;
    breaker_o.breaker_closed_in = closed_ok_i && !opening;
    breaker_o.breaker_open_in   = opening || !closed_ok_i;
    breaker_o.monitor_block_in  = block_i;
    breaker_o.wear_clear_in     = clear_i;
  end
endmodule // breaker_side_model

// [dv/breaker_wear_monitor_bench.sv]
// testbench: wishbone register access and breaker interruption sequences
// assumes the wear monitor and the far side model share one 10 MHz clock
`timescale 1ns/100ps
module breaker_wear_monitor_bench;
  logic                         clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, alarm;
  logic                         go, closed_ok, block, clear;
  logic [7:0]                   wb_adr;
  logic [31:0]                  wb_wdat, wb_rdat, rd;
  logic [1:0]                   sel;
  logic [15:0]                  peak, tail;
  wear_pkg::phase_currents_type phase;
  wear_pkg::breaker_in_type     brk;
  int                           fail_count, cmp_count;
  logic [7:0]  d_adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] d_exp [8] = '{32'h0, 32'h0A, 32'hC350, 32'h64, 32'hC350, 32'h3E8, 32'h0, 32'h0};
  logic [7:0]  c_adr [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] c_wr  [5] = '{32'h05, 32'h0, 32'h30000, 32'h0, 32'h05};
  logic [31:0] c_exp [5] = '{32'h0A, 32'h01, 32'h186A0, 32'h01, 32'h3E8};

  breaker_wear_monitor #(.CAPTURE_CYCLES(50)) breaker_wear_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .phase_i(phase), .breaker_i(brk), .wear_alarm_out_o(alarm));
  breaker_side_model breaker_side_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .phase_sel_i(sel), .peak_i(peak), .tail_i(tail),
    .closed_ok_i(closed_ok), .block_i(block), .clear_i(clear), .phase_o(phase),
    .breaker_o(brk));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_near(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if ($isunknown(got) || got > exp + 32'h60 || got + 32'h60 < exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one classic cycle, read data left in rd
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd     = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wear_is(input string name, input logic [31:0] exp);
    bus(1'b0, wear_pkg::ADDR_WEAR, 32'h0);
    check(name, exp, rd);
  endtask
  task automatic trip_run(input logic [1:0] s, input logic [15:0] pk, input logic [15:0] tl,
                          input logic cl, input logic blk);
    sel       <= s;
    peak      <= pk;
    tail      <= tl;
    closed_ok <= cl;
    go        <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (3) @(posedge clk_i);
    block <= blk;
    repeat (4) @(posedge clk_i);
    block <= 1'b0;
    repeat (70) @(posedge clk_i);
    closed_ok <= 1'b1;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    {rst_i, closed_ok} = 2'b11;
    {wb_cyc, wb_stb, wb_we, go, block, clear} = 6'h00;
    {wb_adr, wb_wdat, sel, peak, tail} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, d_adr[i], 32'h0);
      check("reset value", d_exp[i], rd);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, c_adr[i], c_wr[i]);
      bus(1'b0, c_adr[i], 32'h0);
      check("clamped setting", c_exp[i], rd);
    end
    trip_run(2'h0, 16'h012C, 16'h0000, 1'b1, 1'b0);
    wear_is("wear while off", 32'h0);
    bus(1'b1, wear_pkg::ADDR_CTRL, 32'h1);
    bus(1'b1, wear_pkg::ADDR_CNT_1KA, 32'h64);
    bus(1'b1, wear_pkg::ADDR_CNT_RATE, 32'h64);
    trip_run(2'h0, 16'h012C, 16'h0000, 1'b1, 1'b0);
    wear_is("flat curve wear", 32'h100);
    bus(1'b0, wear_pkg::ADDR_STATUS, 32'h0);
    check("peak current", {16'h0, 16'h012C}, {16'h0, rd[31:16]});
    check("alarm at limit", 32'h0, {31'h0, alarm});
    trip_run(2'h1, 16'h012C, 16'h0000, 1'b0, 1'b0);
    wear_is("trip while open", 32'h100);
    trip_run(2'h1, 16'h012C, 16'h0000, 1'b1, 1'b1);
    wear_is("blocked trip", 32'h100);
    trip_run(2'h1, 16'h012C, 16'h0028, 1'b1, 1'b0);
    wear_is("timed out capture", 32'h100);
    bus(1'b0, wear_pkg::ADDR_STATUS, 32'h0);
    check("abort flag", 32'h1, {31'h0, rd[2]});
    bus(1'b1, wear_pkg::ADDR_MIN_CUR, 32'h32);
    trip_run(2'h2, 16'h00FA, 16'h0028, 1'b1, 1'b0);
    wear_is("raised min current", 32'h200);
    check("alarm over limit", 32'h1, {31'h0, alarm});
    clear <= 1'b1;
    @(posedge clk_i);
    clear <= 1'b0;
    @(posedge clk_i);
    wear_is("cleared wear", 32'h0);
    check("alarm after clear", 32'h0, {31'h0, alarm});
    bus(1'b1, wear_pkg::ADDR_CNT_1KA, 32'h3E8);
    trip_run(2'h1, 16'h0190, 16'h0000, 1'b1, 1'b0);
    bus(1'b0, wear_pkg::ADDR_WEAR, 32'h0);
    check_near("sloped curve wear", 32'h400, rd);
    check("alarm on slope", 32'h1, {31'h0, alarm});
    bus(1'b1, wear_pkg::ADDR_CTRL, 32'h0);
    check("alarm when off", 32'h0, {31'h0, alarm});
    bus(1'b1, wear_pkg::ADDR_WEAR, 32'h500);
    wear_is("restored wear", 32'h500);
    stop_test();
  end
endmodule // breaker_wear_monitor_bench
